// file: rtl/pptc_pkg.sv
// Shared constants for the per-port priority and tag control block.
// Assumes an AXI4-Lite master with 8-bit byte addresses and 32-bit data.
package pptc_pkg;

  // Widths.
  localparam int ADDR_W = 8;
  localparam int VID_W = 12;
  localparam int NPORT = 3;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL_P1 = 8'h10;
  localparam logic [7:0] OFS_CTRL_P2 = 8'h20;
  localparam logic [7:0] OFS_CTRL_P3 = 8'h30;
  localparam logic [7:0] OFS_VID_P1 = 8'h40;
  localparam logic [7:0] OFS_VID_P2 = 8'h44;
  localparam logic [7:0] OFS_VID_P3 = 8'h48;
  localparam logic [7:0] OFS_PCP_MAP = 8'h4C;
  localparam logic [7:0] OFS_STATUS = 8'h50;

  // Decoded register selectors.
  localparam logic [3:0] SEL_CTRL0 = 4'h8;
  localparam logic [3:0] SEL_VID0 = 4'hB;
  localparam logic [3:0] SEL_MAP = 4'hE;
  localparam logic [3:0] SEL_STATUS = 4'hF;
  localparam logic [3:0] SEL_NONE = 4'h0;

  // Control byte field positions.
  localparam int BIT_STORM = 7;
  localparam int BIT_DSCP_EN = 6;
  localparam int BIT_DOT1P_EN = 5;
  localparam int BIT_PORT_PRIO_HI = 4;
  localparam int BIT_PORT_PRIO_LO = 3;
  localparam int BIT_TAG_INSERT = 2;
  localparam int BIT_TAG_REMOVE = 1;
  localparam int BIT_QUEUE_SPLIT = 0;

  // Values after reset.
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [11:0] RST_VID = 12'h001;
  localparam logic [15:0] RST_PCP_MAP = 16'hFA50;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Priority that a tag value maps to through the global table.
  function automatic logic [1:0] pcp_lookup(input logic [15:0] map, input logic [2:0] pcp);
    pcp_lookup = map[{pcp, 1'b0} +: 2];
  endfunction : pcp_lookup

endpackage : pptc_pkg

// file: rtl/pptc_decide.sv
// Per-frame decision logic: ingress priority and egress tag and queue choice.
// Assumes the caller supplies the control byte of the relevant port and registers the results.
`timescale 1ns/1ns
`default_nettype none
module pptc_decide (
  // Ingress frame and its port control.
  input wire logic [7:0] in_ctrl,
  input wire logic [15:0] prio_map,
  input wire logic in_tagged,
  input wire logic [2:0] in_pcp,
  input wire logic in_ipv4,
  input wire logic in_dscp_hit,
  input wire logic [1:0] in_dscp_prio,
  output logic [1:0] cls_prio,
  output logic cls_storm,
  // Egress frame and its port control.
  input wire logic [7:0] eg_ctrl,
  input wire logic eg_tagged,
  input wire logic [1:0] eg_prio,
  output logic eg_insert,
  output logic eg_remove,
  output logic [1:0] eg_queue,
  output logic eg_four_way
);
  import pptc_pkg::*;

  logic dot1p_hit;
  logic dscp_hit;

  // Ingress classification; results that hit are OR'ed, else the port priority stands.
  always_comb
  begin
    dot1p_hit = in_ctrl[BIT_DOT1P_EN] && in_tagged; // RL3
    dscp_hit = in_ctrl[BIT_DSCP_EN] && in_ipv4 && in_dscp_hit; // RL2
    cls_prio = 2'h0;
    if (dot1p_hit)
    begin
      cls_prio = cls_prio | pcp_lookup(prio_map, in_pcp); // RL15 RL5
    end
    if (dscp_hit)
    begin
      cls_prio = cls_prio | in_dscp_prio; // RL5
    end
    if (!dot1p_hit && !dscp_hit)
    begin
      cls_prio = in_ctrl[BIT_PORT_PRIO_HI:BIT_PORT_PRIO_LO]; // RL4
    end
    cls_storm = in_ctrl[BIT_STORM]; // RL1
  end

  // Egress tag handling and queue choice.
  always_comb
  begin
    eg_insert = eg_ctrl[BIT_TAG_INSERT] && !eg_tagged; // RL6
    eg_remove = eg_ctrl[BIT_TAG_REMOVE] && eg_tagged; // RL9 RL10
    eg_four_way = eg_ctrl[BIT_QUEUE_SPLIT]; // RL11
    eg_queue = eg_ctrl[BIT_QUEUE_SPLIT] ? eg_prio : 2'h0; // RL17
  end

endmodule : pptc_decide
`default_nettype wire

// file: rtl/pptc_top.sv
// Per-port ingress/egress control registers with their frame decisions.
// Assumes an AXI4-Lite master on core_clk and a switch datapath on the same clock.
//
// How it works
// RL1 - Control bit 7 turns on broadcast storm protection for frames arriving on that port.
// RL2 - Bit 6 enables DiffServ priority classification of IPv4 ingress frames.
// RL3 - Bit 5 enables 802.1p user priority classification of ingress frames.
// RL4 - Bits 4-3 give the fallback queue when other classification is off or misses.
// RL5 - All classifiers may be on together; OR of 802.1p and DSCP replaces port priority.
// RL6 - Bit 2 inserts a tag on egress only into frames that arrived untagged.
// RL7 - The inserted tag carries the ingress port's default VLAN identifier.
// RL8 - Software sets bits 5-0 of location 194 before relying on tag insertion.
// RL9 - Bit 1 strips the tag on egress from frames that arrived tagged.
// RL10 - With removal on, frames that arrived untagged leave unchanged.
// RL11 - Bit 0 splits the transmit queue into four priority queues; else one queue.
// RL12 - Software never enables four-way and two-way split together on one port.
// RL13 - Three independent copies at 0x10, 0x20 and 0x30 for ports 1 to 3.
// RL14 - Every copy uses the same bit layout; only the address differs.
// RL15 - 802.1p tag values map to two-bit priority through a programmable global table.
// RL16 - A write affects frames starting after it, never frames already decided.
// RL17 - Without the split, every frame goes to the single queue.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module pptc_top (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // AXI4-Lite write channels.
  input wire logic [pptc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [pptc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Ingress frame classification request.
  input wire logic in_valid,
  input wire logic [1:0] in_port,
  input wire logic in_tagged,
  input wire logic [2:0] in_pcp,
  input wire logic in_ipv4,
  input wire logic in_dscp_hit,
  input wire logic [1:0] in_dscp_prio,
  // Ingress classification answer.
  output logic cls_valid,
  output logic [1:0] cls_prio,
  output logic cls_storm,
  // Egress frame request.
  input wire logic eg_valid,
  input wire logic [1:0] eg_port,
  input wire logic [1:0] eg_src_port,
  input wire logic eg_tagged,
  input wire logic [1:0] eg_prio,
  // Egress answer.
  output logic eg_done,
  output logic eg_insert,
  output logic eg_remove,
  output logic [pptc_pkg::VID_W-1:0] eg_vid,
  output logic [1:0] eg_queue,
  output logic eg_four_way
);
  import pptc_pkg::*;

  typedef struct packed {
    logic [NPORT-1:0][7:0] ctrl;
    logic [NPORT-1:0][VID_W-1:0] vid;
    logic [15:0] map;
    logic [NPORT-1:0][1:0] last_prio;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic cls_valid;
    logic [1:0] cls_prio;
    logic cls_storm;
    logic eg_done;
    logic eg_insert;
    logic eg_remove;
    logic [VID_W-1:0] eg_vid;
    logic [1:0] eg_queue;
    logic eg_four_way;
  } pptc_state_t;

  pptc_state_t r;
  pptc_state_t next_r;

  logic [7:0] in_ctrl;
  logic [7:0] eg_ctrl;
  logic [1:0] d_prio;
  logic d_storm;
  logic d_insert;
  logic d_remove;
  logic [1:0] d_queue;
  logic d_four_way;

  // Maps a byte address onto a register selector; every port copy shares one layout.
  function automatic logic [3:0] decode(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_CTRL_P1: decode = SEL_CTRL0; // RL13 RL14
      OFS_CTRL_P2: decode = SEL_CTRL0 + 4'h1; // RL13 RL14
      OFS_CTRL_P3: decode = SEL_CTRL0 + 4'h2; // RL13 RL14
      OFS_VID_P1: decode = SEL_VID0;
      OFS_VID_P2: decode = SEL_VID0 + 4'h1;
      OFS_VID_P3: decode = SEL_VID0 + 4'h2;
      OFS_PCP_MAP: decode = SEL_MAP;
      OFS_STATUS: decode = SEL_STATUS;
      default: decode = SEL_NONE;
    endcase
  endfunction : decode

  // Merges write data into an old word under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++)
    begin
      old[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
    merge = old;
  endfunction : merge

  // Control byte of a port number, zero for the unused code.
  function automatic logic [7:0] port_ctrl(input logic [NPORT-1:0][7:0] c, input logic [1:0] p);
    port_ctrl = (p < 2'(NPORT)) ? c[p] : 8'h00;
  endfunction : port_ctrl

  // Control of the port a frame arrives on and of the port it leaves on.
  always_comb
  begin
    in_ctrl = port_ctrl(r.ctrl, in_port);
    eg_ctrl = port_ctrl(r.ctrl, eg_port);
  end

  pptc_decide u_decide (
    .in_ctrl(in_ctrl),
    .prio_map(r.map),
    .in_tagged(in_tagged),
    .in_pcp(in_pcp),
    .in_ipv4(in_ipv4),
    .in_dscp_hit(in_dscp_hit),
    .in_dscp_prio(in_dscp_prio),
    .cls_prio(d_prio),
    .cls_storm(d_storm),
    .eg_ctrl(eg_ctrl),
    .eg_tagged(eg_tagged),
    .eg_prio(eg_prio),
    .eg_insert(d_insert),
    .eg_remove(d_remove),
    .eg_queue(d_queue),
    .eg_four_way(d_four_way)
  );

  // Next state: frame decisions, then the bus slave, then reset.
  always_comb
  begin
    logic [3:0] wsel;
    logic [3:0] rsel;
    logic [31:0] word;
    wsel = decode(r.aw_addr);
    rsel = decode(s_axi_araddr);
    word = 32'h0000_0000;
    next_r = r;
    // Decisions are sampled from the registers at the frame's request cycle.
    next_r.cls_valid = in_valid && (in_port < 2'(NPORT)); // RL16
    next_r.eg_done = eg_valid && (eg_port < 2'(NPORT)); // RL16
    if (next_r.cls_valid)
    begin
      next_r.cls_prio = d_prio;
      next_r.cls_storm = d_storm;
      next_r.last_prio[in_port] = d_prio;
    end
    if (next_r.eg_done)
    begin
      next_r.eg_insert = d_insert;
      next_r.eg_remove = d_remove;
      next_r.eg_queue = d_queue;
      next_r.eg_four_way = d_four_way;
      next_r.eg_vid = (eg_src_port < 2'(NPORT)) ? r.vid[eg_src_port] : RST_VID; // RL7
    end
    // Write address and data are taken in either order.
    if (s_axi_awvalid && r.awready)
    begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready)
    begin
      next_r.w_held = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end
    if (r.aw_held && r.w_held && !r.bvalid)
    begin
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      for (int p = 0; p < NPORT; p++)
      begin
        if (wsel == SEL_CTRL0 + 4'(p))
        begin
          word = merge({24'h00_0000, r.ctrl[p]}, r.w_data, r.w_strb);
          next_r.ctrl[p] = word[7:0]; // RL13 RL14
        end
        if (wsel == SEL_VID0 + 4'(p))
        begin
          word = merge({20'h0_0000, r.vid[p]}, r.w_data, r.w_strb);
          next_r.vid[p] = word[VID_W-1:0];
        end
      end
      if (wsel == SEL_MAP)
      begin
        word = merge({16'h0000, r.map}, r.w_data, r.w_strb);
        next_r.map = word[15:0]; // RL15
      end
      if (wsel == SEL_NONE)
      begin
        next_r.bresp = RESP_SLVERR;
      end
    end
    else if (r.bvalid && s_axi_bready)
    begin
      next_r.bvalid = 1'b0;
    end
    // Read: one cycle from address to data.
    if (s_axi_arvalid && r.arready)
    begin
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      next_r.rdata = 32'h0000_0000;
      for (int p = 0; p < NPORT; p++)
      begin
        if (rsel == SEL_CTRL0 + 4'(p))
        begin
          next_r.rdata[7:0] = r.ctrl[p];
        end
        if (rsel == SEL_VID0 + 4'(p))
        begin
          next_r.rdata[VID_W-1:0] = r.vid[p];
        end
      end
      if (rsel == SEL_MAP)
      begin
        next_r.rdata[15:0] = r.map;
      end
      if (rsel == SEL_STATUS)
      begin
        next_r.rdata[5:0] = r.last_prio;
      end
      if (rsel == SEL_NONE)
      begin
        next_r.rresp = RESP_SLVERR;
      end
    end
    else if (r.rvalid && s_axi_rready)
    begin
      next_r.rvalid = 1'b0;
    end
    next_r.awready = !next_r.aw_held && !next_r.bvalid;
    next_r.wready = !next_r.w_held && !next_r.bvalid;
    next_r.arready = !next_r.rvalid;
    // Synchronous reset.
    if (!rst_n)
    begin
      next_r = '0;
      next_r.ctrl = {NPORT{RST_CTRL}};
      next_r.vid = {NPORT{RST_VID}};
      next_r.map = RST_PCP_MAP;
    end
  end

  // State register.
  always_ff @(posedge core_clk)
  begin
    r <= next_r;
  end

  // Outputs straight from the state register.
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bresp = r.bresp;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_arready = r.arready;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rvalid = r.rvalid;
  assign cls_valid = r.cls_valid;
  assign cls_prio = r.cls_prio;
  assign cls_storm = r.cls_storm;
  assign eg_done = r.eg_done;
  assign eg_insert = r.eg_insert;
  assign eg_remove = r.eg_remove;
  assign eg_vid = r.eg_vid;
  assign eg_queue = r.eg_queue;
  assign eg_four_way = r.eg_four_way;

  // Checks of the frame decisions against the registers that steer them.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  chk_storm_follows_bit: assert property ( // RL1
    in_valid && in_port != 2'h3 |=> cls_valid && cls_storm == $past(in_ctrl[BIT_STORM]))
    else $error("Storm flag does not follow control bit 7.");
  chk_dscp_only_prio: assert property ( // RL2
    in_valid && in_port != 2'h3 && in_ctrl[6:5] == 2'b10 && in_ipv4 && in_dscp_hit
    |=> cls_prio == $past(in_dscp_prio))
    else $error("DiffServ priority not used.");
  chk_dot1p_only_prio: assert property ( // RL3
    in_valid && in_port != 2'h3 && in_ctrl[6:5] == 2'b01 && in_tagged
    |=> cls_prio == $past(pcp_lookup(r.map, in_pcp)))
    else $error("802.1p mapped priority not used.");
  chk_port_fallback: assert property ( // RL4
    in_valid && in_port != 2'h3 && in_ctrl[6:5] == 2'b00
    |=> cls_prio == $past(in_ctrl[4:3]))
    else $error("Port fallback priority not used.");
  chk_or_of_both: assert property ( // RL5
    in_valid && in_port != 2'h3 && in_ctrl[6:5] == 2'b11 && in_tagged && in_ipv4 && in_dscp_hit
    |=> cls_prio == ($past(in_dscp_prio) | $past(pcp_lookup(r.map, in_pcp))))
    else $error("Combined priority is not the OR of both.");
  chk_insert_untagged: assert property ( // RL6
    eg_valid && eg_port != 2'h3 |=> eg_done && eg_insert == $past(eg_ctrl[2] && !eg_tagged))
    else $error("Tag insertion decision wrong.");
  chk_ingress_vid: assert property ( // RL7
    eg_valid && eg_port != 2'h3 && eg_src_port != 2'h3 |=> eg_vid == $past(r.vid[eg_src_port]))
    else $error("Inserted VID is not the ingress port's.");
  chk_remove_tagged: assert property ( // RL9 RL10
    eg_valid && eg_port != 2'h3 |=> eg_remove == $past(eg_ctrl[1] && eg_tagged))
    else $error("Tag removal decision wrong.");
  chk_single_queue: assert property ( // RL11 RL17
    eg_valid && eg_port != 2'h3 && !eg_ctrl[0] |=> eg_queue == 2'h0 && !eg_four_way)
    else $error("Frame left the single queue while unsplit.");

endmodule : pptc_top
`default_nettype wire

// file: verification/pptc_bench.sv
// Self-checking bench for the per-port priority and tag control block.
// Assumes the design top with its AXI4-Lite slave and frame decision ports on one clock.
`timescale 1ns/1ns
`default_nettype none
module port_priority_tag_control_bench;
  import pptc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic in_valid = 1'b0, in_tagged = 1'b0, in_ipv4 = 1'b0, in_dscp_hit = 1'b0;
  logic [1:0] in_port = 2'h0, in_dscp_prio = 2'h0;
  logic [2:0] in_pcp = 3'h0;
  logic cls_valid, cls_storm;
  logic [1:0] cls_prio;
  logic eg_valid = 1'b0, eg_tagged = 1'b0;
  logic [1:0] eg_port = 2'h0, eg_src_port = 2'h0, eg_prio = 2'h0;
  logic eg_done, eg_insert, eg_remove, eg_four_way;
  logic [11:0] eg_vid;
  logic [1:0] eg_queue;
  int n_fail = 0;
  int tests_run = 0;
  logic [7:0] m_ctrl [3];
  logic [11:0] m_vid [3];
  logic [15:0] m_map;
  logic [5:0] m_last = 6'h00;

  // Device under test, every port connected.
  pptc_top dut_u (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .in_valid, .in_port, .in_tagged, .in_pcp,
    .in_ipv4, .in_dscp_hit, .in_dscp_prio, .cls_valid, .cls_prio, .cls_storm, .eg_valid,
    .eg_port, .eg_src_port, .eg_tagged, .eg_prio, .eg_done, .eg_insert, .eg_remove,
    .eg_vid, .eg_queue, .eg_four_way);

  // Free-running core clock of 100 MHz.
  always #5 core_clk = ~core_clk;

  // Compares one value and counts it.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // One AXI4-Lite write; ready is registered, so its level at the falling edge holds.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_done, w_done, a_hit, w_hit;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(negedge core_clk);
      a_hit = (s_axi_awready === 1'b1) && !aw_done;
      w_hit = (s_axi_wready === 1'b1) && !w_done;
      @(posedge core_clk);
      if (a_hit)
        s_axi_awvalid <= 1'b0;
      if (w_hit)
        s_axi_wvalid <= 1'b0;
      aw_done = aw_done | a_hit;
      w_done = w_done | w_hit;
    end
    do @(negedge core_clk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    @(posedge core_clk);
    s_axi_bready <= 1'b0;
  endtask : axi_write

  // One AXI4-Lite read returning data and response.
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge core_clk); while (s_axi_arready !== 1'b1);
    @(posedge core_clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge core_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge core_clk);
    s_axi_rready <= 1'b0;
  endtask : axi_read

  // Expected ingress priority from the control byte and frame fields.
  function automatic logic [1:0] exp_prio(input logic [7:0] c, input logic tg,
                                          input logic [2:0] pcp, input logic ip,
                                          input logic hit, input logic [1:0] dp);
    logic a, b;
    logic [1:0] r;
    a = c[5] && tg;
    b = c[6] && ip && hit;
    r = 2'b00;
    if (a)
      r = r | m_map[pcp*2 +: 2];
    if (b)
      r = r | dp;
    if (!a && !b)
      r = c[4:3];
    return r;
  endfunction : exp_prio

  // Watchdog that cuts a hang short; the tests need well under 2,000 cycles, it waits 10,000.
  initial
  begin
    #100000;
    n_fail++;
    report_and_stop();
  end

  // Main sequence of tests.
  initial
  begin
    logic [31:0] d;
    logic [1:0] rs;
    logic [1:0] p;
    logic [7:0] c;
    logic [1:0] e;
    void'($urandom(4));
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      axi_read(OFS_CTRL_P1 + 8'(16 * i), d, rs);
      check(d, 32'h0000_0000);
      check({30'h0, rs}, {30'h0, RESP_OKAY});
      m_ctrl[i] = 8'h00;
    end
    axi_read(OFS_PCP_MAP, d, rs);
    check(d, {16'h0000, RST_PCP_MAP});
    axi_read(8'h14, d, rs);
    check(d, 32'h0000_0000);
    check({30'h0, rs}, {30'h0, RESP_SLVERR});
    axi_write(8'h14, 32'h0000_00FF, rs);
    check({30'h0, rs}, {30'h0, RESP_SLVERR});
    $display("test reset_and_unmapped done");
    m_map = 16'($urandom());
    axi_write(OFS_PCP_MAP, {16'h0000, m_map}, rs);
    for (int i = 0; i < 3; i++)
    begin
      m_vid[i] = 12'($urandom());
      axi_write(OFS_VID_P1 + 8'(4 * i), {20'h0_0000, m_vid[i]}, rs);
    end
    // Each port gets its own random byte; the others must not change.
    for (int i = 0; i < 3; i++)
    begin
      m_ctrl[i] = 8'($urandom());
      axi_write(OFS_CTRL_P1 + 8'(16 * i), {24'h00_0000, m_ctrl[i]}, rs);
    end
    for (int i = 0; i < 3; i++)
    begin
      axi_read(OFS_CTRL_P1 + 8'(16 * i), d, rs);
      check(d, {24'h00_0000, m_ctrl[i]});
    end
    $display("test register_copies done");
    // Random frames on random ports, one reprogrammed every fourth frame; port code 3 must be ignored.
    for (int n = 0; n < 120; n++)
    begin
      p = 2'($urandom_range(0, 2));
      // The two-way split lives outside this block and stays off, and tag enabling is assumed.
      c = 8'($urandom());
      if (n % 4 == 0)
      begin
        axi_write(OFS_CTRL_P1 + 8'(16 * p), {24'h00_0000, c}, rs);
        m_ctrl[p] = c;
      end
      @(posedge core_clk);
      in_valid <= 1'b1;
      in_port <= (n % 10 == 9) ? 2'h3 : p;
      in_tagged <= 1'($urandom());
      in_pcp <= 3'($urandom());
      in_ipv4 <= 1'($urandom());
      in_dscp_hit <= 1'($urandom());
      in_dscp_prio <= 2'($urandom());
      eg_valid <= 1'b1;
      eg_port <= (n % 7 == 6) ? 2'h3 : p;
      eg_src_port <= 2'($urandom());
      eg_tagged <= 1'($urandom());
      eg_prio <= 2'($urandom());
      @(posedge core_clk);
      in_valid <= 1'b0;
      eg_valid <= 1'b0;
      #1;
      if (in_port == 2'h3)
        check({31'h0, cls_valid}, 32'h0);
      else
      begin
        e = exp_prio(m_ctrl[p], in_tagged, in_pcp, in_ipv4, in_dscp_hit, in_dscp_prio);
        m_last[p*2 +: 2] = e;
        check({31'h0, cls_valid}, 32'h1);
        check({31'h0, cls_storm}, {31'h0, m_ctrl[p][7]});
        check({30'h0, cls_prio}, {30'h0, e});
      end
      // Egress port code 3 names no port and must get no answer.
      if (eg_port == 2'h3)
        check({31'h0, eg_done}, 32'h0);
      else
      begin
        check({31'h0, eg_done}, 32'h1);
        check({31'h0, eg_insert}, {31'h0, m_ctrl[p][2] && !eg_tagged});
        check({31'h0, eg_remove}, {31'h0, m_ctrl[p][1] && eg_tagged});
        check({20'h0, eg_vid},
          {20'h0, (eg_src_port == 2'h3) ? RST_VID : m_vid[eg_src_port]});
        check({31'h0, eg_four_way}, {31'h0, m_ctrl[p][0]});
        check({30'h0, eg_queue}, {30'h0, m_ctrl[p][0] ? eg_prio : 2'h0});
      end
    end
    // The status word must show the last priority classified on each port.
    axi_read(OFS_STATUS, d, rs);
    check(d, {26'h000_0000, m_last});
    $display("test random_frames done");
    report_and_stop();
  end
endmodule : port_priority_tag_control_bench
`default_nettype wire
